// *** include/tf_params.svh ***
`ifndef TF_PARAMS_SVH
`define TF_PARAMS_SVH

// Register indices; byte address is four times the index
`define TF_TIMING_IDX 10'h052
`define TF_STATUS_IDX 10'h060
`define TF_TIMING_RST 8'hAF

// Timing register fields
`define TF_ACT_MSB 7
`define TF_ACT_LSB 4
`define TF_REC_MSB 3
`define TF_REC_LSB 0
`define TF_NIBBLE_MAX 4'hF
`define TF_ACT_ZERO_UNITS 5'h10
`define TF_REC_MIN_UNITS 5'h01

// Status register fields
`define TF_ST_BUSY 0
`define TF_ST_CHAN 1
`define TF_ST_WRITE 2
`define TF_ST_CNT_LSB 16
`define TF_ST_CNT_MSB 31

// Timing: counts are in bus clock units, converted to system cycles
`define TF_SYS_PERIOD_NS 10
`define TF_UNIT_PERIOD_NS 30
`define TF_UNIT_CYCLES ((`TF_UNIT_PERIOD_NS + `TF_SYS_PERIOD_NS - 1) / `TF_SYS_PERIOD_NS)
`define TF_CNT_W 8

// Reference settings and their expected unit counts
`define TF_EX_SLOW 8'hAF
`define TF_EX_SLOW_ACT 10
`define TF_EX_SLOW_REC 1
`define TF_EX_FAST 8'h32
`define TF_EX_FAST_ACT 3
`define TF_EX_FAST_REC 3

`endif

// *** include/tf_pkg.sv ***
`default_nettype none
`include "tf_params.svh"

package tf_pkg;

    localparam int CNT_W = `TF_CNT_W;

    typedef enum logic [1:0] {T_IDLE, T_ACTIVE, T_RECOVER} strobe_state_t;

    typedef struct packed {
        strobe_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] rec_cyc;
        logic [1:0] rd_n;
        logic [1:0] wr_n;
        logic ready;
    } timer_regs_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] timing;
        logic [15:0] acc_count;
        logic last_chan;
        logic last_write;
    } host_regs_t;

endpackage : tf_pkg

`default_nettype wire

// *** src/tf_host_port.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tf_params.svh"

// How it works
// RQ1: Task file accesses always use task-file strobe timing
// RQ2: Timing register index 0x52, active/recovery nibbles
// RQ3: New timing applies to both channels
// RQ4: Counts are in bus-clock units of 30 ns
// RQ5: Recovery is never shorter than one unit
// RQ6: Value 0xAF gives ten active, one recovery
// RQ7: Value 0x32 gives three active, three recovery
// RQ8: Software programs times meeting mode minimums
// RQ9: Software sets drive mode before timing
// RQ10: Strobe active exactly, recovery at least, programmed
module tf_host_port #(
    parameter int UNIT_CYCLES = `TF_UNIT_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Task file access requests
    input wire logic tf_req_i,
    input wire logic tf_chan_i,
    input wire logic tf_write_i,
    output logic tf_ready_o,
    // Drive strobes, index is the channel
    output logic [1:0] dior_n_o,
    output logic [1:0] diow_n_o
);
    import tf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Nibble decoding

    // Zero active nibble is read as sixteen units rather than no strobe
    function automatic logic [CNT_W-1:0] act_cycles(input logic [7:0] t);
        logic [4:0] u;
        u = (t[`TF_ACT_MSB:`TF_ACT_LSB] == 4'h0) ? `TF_ACT_ZERO_UNITS // RQ6
            : {1'b0, t[`TF_ACT_MSB:`TF_ACT_LSB]};
        return CNT_W'(u * UNIT_CYCLES); // RQ4
    endfunction : act_cycles

    // Field holds recovery minus one; all ones wraps to the one-unit floor
    function automatic logic [CNT_W-1:0] rec_cycles(input logic [7:0] t);
        logic [4:0] u;
        u = (t[`TF_REC_MSB:`TF_REC_LSB] == `TF_NIBBLE_MAX) ? `TF_REC_MIN_UNITS // RQ7
            : {1'b0, t[`TF_REC_MSB:`TF_REC_LSB]} + 5'h01; // RQ5
        return CNT_W'(u * UNIT_CYCLES); // RQ4
    endfunction : rec_cycles

    ////////////////////////////////////////////////////////////////////////////
    // State

    host_regs_t r;
    host_regs_t next_r;
    logic accept;
    logic setup;
    logic wr_done;
    logic [9:0] idx;
    logic [CNT_W-1:0] cur_act;
    logic [CNT_W-1:0] cur_rec;

    assign accept = tf_req_i && tf_ready_o;
    assign setup = psel_i && !penable_i;
    assign wr_done = psel_i && penable_i && r.pready && pwrite_i;
    assign idx = paddr_i[11:2];
    // One timing source feeds the shared timer for both channels
    assign cur_act = act_cycles(r.timing); // RQ3
    assign cur_rec = rec_cycles(r.timing); // RQ3

    always_comb
    begin
        next_r = r;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        // Answer in the first access cycle; read data captured at setup
        if (setup)
        begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            if (idx == `TF_TIMING_IDX)
            begin
                if (!pwrite_i)
                    next_r.prdata[7:0] = r.timing; // RQ2
            end
            else if (idx == `TF_STATUS_IDX)
            begin
                if (!pwrite_i)
                begin
                    next_r.prdata[`TF_ST_BUSY] = !tf_ready_o;
                    next_r.prdata[`TF_ST_CHAN] = r.last_chan;
                    next_r.prdata[`TF_ST_WRITE] = r.last_write;
                    next_r.prdata[`TF_ST_CNT_MSB:`TF_ST_CNT_LSB] = r.acc_count;
                end
            end
            else
            begin
                next_r.pslverr = 1'b1;
            end
        end
        if (wr_done && idx == `TF_TIMING_IDX && pstrb_i[0])
            next_r.timing = pwdata_i[7:0]; // RQ2
        if (accept)
        begin
            next_r.acc_count = r.acc_count + 16'h0001;
            next_r.last_chan = tf_chan_i;
            next_r.last_write = tf_write_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r.prdata <= 32'h0000_0000;
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            r.timing <= `TF_TIMING_RST;
            r.acc_count <= 16'h0000;
            r.last_chan <= 1'b0;
            r.last_write <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign prdata_o = r.prdata;
    assign pready_o = r.pready;
    assign pslverr_o = r.pslverr;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe timer, shared by both channels

    // Drive mode is not an input: every access takes the task file timing
    tf_strobe_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .start_i(accept), // RQ1
        .chan_i(tf_chan_i),
        .write_i(tf_write_i),
        .act_cyc_i(cur_act),
        .rec_cyc_i(cur_rec),
        .rd_n_o(dior_n_o),
        .wr_n_o(diow_n_o),
        .ready_o(tf_ready_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertion helpers

    logic strobe_low;
    logic [CNT_W-1:0] low_len;
    logic [CNT_W-1:0] high_len;
    logic [CNT_W-1:0] exp_act;
    logic [CNT_W-1:0] exp_rec;
    logic seen_end;
    logic [7:0] last_wr;

    assign strobe_low = !(&{dior_n_o, diow_n_o});

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            low_len <= '0;
            high_len <= '0;
            exp_act <= '0;
            exp_rec <= '0;
            seen_end <= 1'b0;
            last_wr <= `TF_TIMING_RST;
        end
        else
        begin
            low_len <= strobe_low ? low_len + 1'b1 : '0;
            // Saturates so a long idle spell never wraps to a short gap
            high_len <= strobe_low ? '0 : ((&high_len) ? high_len : high_len + 1'b1);
            if (wr_done && idx == `TF_TIMING_IDX && pstrb_i[0])
                last_wr <= pwdata_i[7:0];
            if (accept)
            begin
                exp_act <= cur_act;
                exp_rec <= cur_rec;
            end
            if (!strobe_low && low_len != '0)
                seen_end <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_take_read(c);
        accept && !tf_write_i && tf_chan_i == c;
    endsequence

    sequence s_read_only(c);
        !dior_n_o[c] && dior_n_o[!c] && &diow_n_o;
    endsequence

    property p_rq1;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_take_read(tf_chan_i) |=> s_read_only($past(tf_chan_i))
            ##1 (tf_ready_o == (exp_act == CNT_W'(1) && exp_rec == CNT_W'(1)));
    endproperty
    a_rq1: assert property (p_rq1) else $error("read strobe not on selected channel"); // RQ1

    property p_rq1_wr;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (accept && tf_write_i) |=> !diow_n_o[$past(tf_chan_i)] && &dior_n_o;
    endproperty
    a_rq1_wr: assert property (p_rq1_wr) else $error("write strobe not on selected channel"); // RQ1

    property p_rq2;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (wr_done && idx == `TF_TIMING_IDX && pstrb_i[0])
            |=> r.timing == $past(pwdata_i[7:0]) ##1 r.timing == $past(r.timing);
    endproperty
    a_rq2: assert property (p_rq2) else $error("timing register write lost"); // RQ2

    property p_rq3;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        accept |-> cur_act == act_cycles(last_wr)
            && cur_rec == rec_cycles(last_wr);
    endproperty
    a_rq3: assert property (p_rq3) else $error("access ignored current timing"); // RQ3

    property p_rq4;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (!strobe_low && $past(strobe_low)) |-> (low_len % UNIT_CYCLES) == 0;
    endproperty
    a_rq4: assert property (p_rq4) else $error("active time not whole units"); // RQ4

    property p_rq5;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        accept |-> cur_rec >= CNT_W'(UNIT_CYCLES);
    endproperty
    a_rq5: assert property (p_rq5) else $error("recovery below one unit"); // RQ5

    property p_rq6;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (accept && r.timing == `TF_EX_SLOW)
            |-> cur_act == CNT_W'(`TF_EX_SLOW_ACT * UNIT_CYCLES)
            && cur_rec == CNT_W'(`TF_EX_SLOW_REC * UNIT_CYCLES);
    endproperty
    a_rq6: assert property (p_rq6) else $error("slow setting timing wrong"); // RQ6

    property p_rq7;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (accept && r.timing == `TF_EX_FAST)
            |-> cur_act == CNT_W'(`TF_EX_FAST_ACT * UNIT_CYCLES)
            && cur_rec == CNT_W'(`TF_EX_FAST_REC * UNIT_CYCLES);
    endproperty
    a_rq7: assert property (p_rq7) else $error("fast setting timing wrong"); // RQ7

    property p_rq10_act;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (!strobe_low && $past(strobe_low)) |-> low_len == exp_act;
    endproperty
    a_rq10_act: assert property (p_rq10_act) else $error("active length wrong"); // RQ10

    property p_rq10_rec;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (accept && seen_end && !strobe_low) |-> ({1'b0, high_len} + 9'h001) >= {1'b0, exp_rec};
    endproperty
    a_rq10_rec: assert property (p_rq10_rec) else $error("recovery too short"); // RQ10

endmodule : tf_host_port

`default_nettype wire

// *** src/tf_strobe_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module tf_strobe_timer
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Access request
    input wire logic start_i,
    input wire logic chan_i,
    input wire logic write_i,
    input wire logic [tf_pkg::CNT_W-1:0] act_cyc_i,
    input wire logic [tf_pkg::CNT_W-1:0] rec_cyc_i,
    // Strobes and status
    output logic [1:0] rd_n_o,
    output logic [1:0] wr_n_o,
    output logic ready_o
);
    import tf_pkg::*;

    timer_regs_t r;
    timer_regs_t next_r;
    logic fire;

    always_comb
    begin
        next_r = r;
        fire = start_i && r.ready;
        unique case (r.state)
            T_IDLE:
            begin
                next_r.state = T_IDLE;
            end
            T_ACTIVE:
            begin
                if (r.cnt == '0)
                begin
                    next_r.rd_n = 2'h3;
                    next_r.wr_n = 2'h3;
                    next_r.state = T_RECOVER;
                    next_r.cnt = r.rec_cyc - 1'b1;
                end
                else
                begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            T_RECOVER:
            begin
                if (r.cnt == '0)
                    next_r.state = T_IDLE;
                else
                    next_r.cnt = r.cnt - 1'b1;
            end
            // Unused code falls back to idle
            default:
            begin
                next_r.state = T_IDLE;
            end
        endcase
        // Last recovery cycle overlaps the next take, so spacing is exact
        if (fire)
        begin
            next_r.state = T_ACTIVE;
            next_r.cnt = act_cyc_i - 1'b1; // RQ10
            next_r.rec_cyc = rec_cyc_i;
            if (write_i)
                next_r.wr_n[chan_i] = 1'b0; // RQ1
            else
                next_r.rd_n[chan_i] = 1'b0;
        end
        next_r.ready = (next_r.state == T_IDLE) ||
            (next_r.state == T_RECOVER && next_r.cnt == '0); // RQ10
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r.state <= T_IDLE;
            r.cnt <= '0;
            r.rec_cyc <= '0;
            r.rd_n <= 2'h3;
            r.wr_n <= 2'h3;
            r.ready <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rd_n_o = r.rd_n;
    assign wr_n_o = r.wr_n;
    assign ready_o = r.ready;

endmodule : tf_strobe_timer

`default_nettype wire

// *** test/ata_taskfile_pio_strobe_timing_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tf_params.svh"

module ata_taskfile_pio_strobe_timing_test;
    import tf_pkg::*;

    localparam int U = 2;
    localparam logic [11:0] A_TIM = {`TF_TIMING_IDX, 2'h0};
    localparam logic [11:0] A_ST = {`TF_STATUS_IDX, 2'h0};
    typedef struct packed {logic c; logic w; logic [7:0] wid; logic [7:0] gap;} note_t;

    logic sys_clk_i, rstn_i, psel, penable, pwrite, pready, pslverr;
    logic tf_req, tf_chan, tf_write, tf_ready, done, m_c, m_w, err, last_c, last_w;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] dior_n, diow_n;
    logic [3:0] pstrb;
    logic [7:0] m_wid, m_gap, tv, prev_t;
    logic [7:0] edge_t [5] = '{8'h0F, 8'h00, 8'h3F, 8'h30, 8'hF0};
    note_t notes[$];
    note_t en;
    int fails, checks, seed, taken;

    tf_host_port #(.UNIT_CYCLES(U)) dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .tf_req_i(tf_req), .tf_chan_i(tf_chan),
        .tf_write_i(tf_write), .tf_ready_o(tf_ready), .dior_n_o(dior_n), .diow_n_o(diow_n));

    tf_drive_model drive (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .dior_n_i(dior_n),
        .diow_n_i(diow_n), .done_o(done), .chan_o(m_c), .write_o(m_w),
        .width_o(m_wid), .gap_o(m_gap));

    initial
    begin
        sys_clk_i = 1'h0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////
    function automatic int act(input logic [7:0] t);
        return (t[7:4] == 4'h0) ? 16 : int'(t[7:4]);
    endfunction : act

    function automatic int rec(input logic [7:0] t);
        return (t[3:0] == 4'hF) ? 1 : int'(t[3:0]) + 1;
    endfunction : rec

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'h1;
        for (n = 0; n < 20 && pready !== 1'h1; n++)
            @(posedge sys_clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n == 20)
        begin
            fails++;
            final_report;
        end
    endtask : apb

    task automatic apb_rd(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(a, 1'h0, 32'h0);
        check(rd, d);
        check(32'(err), 32'(e));
    endtask : apb_rd

    // Waits until the previous strobe has been measured and recovered
    task automatic drain;
        int n;
        for (n = 0; n < 400 && !(notes.size() == 0 && tf_ready === 1'h1); n++)
            @(posedge sys_clk_i);
        if (n == 400)
        begin
            fails++;
            final_report;
        end
    endtask : drain

    // Drive mode is assumed set before timing is programmed
    task automatic wr_tim(input logic [7:0] t);
        drain;
        apb(A_TIM, 1'h1, {24'h0, t});
        apb_rd(A_TIM, {24'h0, t}, 1'h0);
    endtask : wr_tim

    task automatic strobe(input logic c, input logic w, input logic [7:0] t);
        int n;
        note_t nt;
        nt = {c, w, 8'(act(t) * U), 8'(rec(prev_t) * U)};
        prev_t = t;
        @(posedge sys_clk_i);
        tf_req <= 1'h1;
        tf_chan <= c;
        tf_write <= w;
        // Release at the very edge that takes the request
        for (n = 0; n < 200; n++)
        begin
            @(posedge sys_clk_i);
            if (tf_ready === 1'h1)
                break;
        end
        notes.push_back(nt);
        taken++;
        last_c = c;
        last_w = w;
        tf_req <= 1'h0;
        if (n == 200)
        begin
            fails++;
            final_report;
        end
    endtask : strobe

    always @(posedge sys_clk_i)
    begin
        if (done === 1'h1)
        begin
            en = notes.pop_front();
            check(32'({m_c, m_w, m_wid}), 32'({en.c, en.w, en.wid}));
            check(32'(m_gap >= en.gap), 32'h1);
        end
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        {rstn_i, psel, penable, pwrite, tf_req, tf_chan, tf_write} = 7'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        seed = 59623;
        prev_t = 8'hAF;
        repeat (8) @(posedge sys_clk_i);
        rstn_i <= 1'h1;
        apb_rd(A_TIM, 32'hAF, 1'h0);
        check(32'({dior_n, diow_n}), 32'hF);
        $display("Test reset done");
        strobe(1'h0, 1'h0, 8'hAF);
        strobe(1'h1, 1'h1, 8'hAF);
        $display("Test default timing done");
        wr_tim(8'h32);
        strobe(1'h1, 1'h0, 8'h32);
        strobe(1'h0, 1'h1, 8'h32);
        $display("Test fast timing done");
        foreach (edge_t[i])
        begin
            wr_tim(edge_t[i]);
            strobe(i[0], i[1], edge_t[i]);
            strobe(!i[0], i[1], edge_t[i]);
        end
        $display("Test boundary timing done");
        repeat (6)
        begin
            tv = 8'($random(seed));
            wr_tim(tv);
            strobe(tv[0], tv[1], tv);
            strobe(tv[2], tv[3], tv);
        end
        $display("Test random timing done");
        drain;
        apb(12'h004, 1'h1, 32'hFFFF_FFFF);
        check(32'(err), 32'h1);
        apb_rd(12'h004, 32'h0, 1'h1);
        apb(A_ST, 1'h1, 32'h0);
        apb_rd(A_ST, {16'(taken), 13'h0, last_w, last_c, 1'h0}, 1'h0);
        // Lane 0 strobe off: timing must not change
        pstrb <= 4'hE;
        apb(A_TIM, 1'h1, 32'h0000_0055);
        pstrb <= 4'hF;
        apb_rd(A_TIM, {24'h0, tv}, 1'h0);
        $display("Test register access done");
        final_report;
    end
endmodule : ata_taskfile_pio_strobe_timing_test

`default_nettype wire

// *** test/tf_drive_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module tf_drive_model
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Strobes from the host
    input wire logic [1:0] dior_n_i,
    input wire logic [1:0] diow_n_i,
    // Measurement of the last strobe
    output logic done_o,
    output logic chan_o,
    output logic write_o,
    output logic [7:0] width_o,
    output logic [7:0] gap_o
);
    logic low;
    logic was_low;
    logic [7:0] width;
    logic [7:0] gap;

    assign low = !((&dior_n_i) && (&diow_n_i));

    ////////////////////////////////////////////////////////////////
    // Gap saturates, so the first strobe after reset always passes
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            done_o <= 1'h0;
            chan_o <= 1'h0;
            write_o <= 1'h0;
            width_o <= 8'h00;
            gap_o <= 8'h00;
            was_low <= 1'h0;
            width <= 8'h00;
            gap <= 8'hFF;
        end
        else
        begin
            done_o <= 1'h0;
            was_low <= low;
            if (low)
            begin
                width <= width + 8'h01;
                if (!was_low)
                begin
                    gap_o <= gap;
                    chan_o <= !dior_n_i[1] || !diow_n_i[1];
                    write_o <= diow_n_i != 2'h3;
                end
            end
            else if (was_low)
            begin
                done_o <= 1'h1;
                width_o <= width;
                width <= 8'h00;
                gap <= 8'h01;
            end
            else if (gap != 8'hFF)
            begin
                gap <= gap + 8'h01;
            end
        end
    end
endmodule : tf_drive_model

`default_nettype wire
